// >>> common/swl_pkg.sv
// Shared constants, codes and types for the single-wire ROM command layer
package swl_pkg;

   localparam int CLK_MHZ = 20;

   // Device-side times in microseconds and their cycle counts
   localparam int T_RSTDET_STD_US = 120;
   localparam int T_RSTDET_OD_US  = 16;
   localparam int T_ODEXIT_US     = 480;
   localparam int T_PDH_STD_US    = 30;
   localparam int T_PDH_OD_US     = 3;
   localparam int T_PDL_STD_US    = 100;
   localparam int T_PDL_OD_US     = 10;
   localparam int T_DSAMP_STD_US  = 30;
   localparam int T_DSAMP_OD_US   = 3;

   localparam logic [15:0] C_RSTDET_STD = 16'(T_RSTDET_STD_US * CLK_MHZ);
   localparam logic [15:0] C_RSTDET_OD  = 16'(T_RSTDET_OD_US * CLK_MHZ);
   localparam int          C_ODEXIT     = T_ODEXIT_US * CLK_MHZ;
   localparam logic [15:0] C_PDH_STD    = 16'(T_PDH_STD_US * CLK_MHZ);
   localparam logic [15:0] C_PDH_OD     = 16'(T_PDH_OD_US * CLK_MHZ);
   localparam logic [15:0] C_PDL_STD    = 16'(T_PDL_STD_US * CLK_MHZ);
   localparam logic [15:0] C_PDL_OD     = 16'(T_PDL_OD_US * CLK_MHZ);
   localparam logic [15:0] C_DSAMP_STD  = 16'(T_DSAMP_STD_US * CLK_MHZ);
   localparam logic [15:0] C_DSAMP_OD   = 16'(T_DSAMP_OD_US * CLK_MHZ);

   // Master-side times in microseconds and their cycle counts
   localparam int T_RSTL_STD_US = 480;
   localparam int T_RSTL_OD_US  = 50;
   localparam int T_MSP_STD_US  = 70;
   localparam int T_MSP_OD_US   = 8;
   localparam int T_RSTH_STD_US = 480;
   localparam int T_RSTH_OD_US  = 48;
   localparam int T_W0L_STD_US  = 60;
   localparam int T_W0L_OD_US   = 6;
   localparam int T_W1L_STD_US  = 5;
   localparam int T_W1L_OD_US   = 1;
   localparam int T_MSR_STD_US  = 15;
   localparam int T_MSR_OD_US   = 2;
   localparam int T_SLOT_STD_US = 70;
   localparam int T_SLOT_OD_US  = 10;

   localparam int          C_RSTL_STD = T_RSTL_STD_US * CLK_MHZ;
   localparam logic [15:0] C_RSTL_OD  = 16'(T_RSTL_OD_US * CLK_MHZ);
   localparam logic [15:0] C_MSP_STD  = 16'(T_MSP_STD_US * CLK_MHZ);
   localparam logic [15:0] C_MSP_OD   = 16'(T_MSP_OD_US * CLK_MHZ);
   localparam int          C_RSTH_STD = T_RSTH_STD_US * CLK_MHZ;
   localparam logic [15:0] C_RSTH_OD  = 16'(T_RSTH_OD_US * CLK_MHZ);
   localparam logic [15:0] C_W0L_STD  = 16'(T_W0L_STD_US * CLK_MHZ);
   localparam logic [15:0] C_W0L_OD   = 16'(T_W0L_OD_US * CLK_MHZ);
   localparam logic [15:0] C_W1L_STD  = 16'(T_W1L_STD_US * CLK_MHZ);
   localparam logic [15:0] C_W1L_OD   = 16'(T_W1L_OD_US * CLK_MHZ);
   localparam logic [15:0] C_MSR_STD  = 16'(T_MSR_STD_US * CLK_MHZ);
   localparam logic [15:0] C_MSR_OD   = 16'(T_MSR_OD_US * CLK_MHZ);
   localparam logic [15:0] C_SLOT_STD = 16'(T_SLOT_STD_US * CLK_MHZ);
   localparam logic [15:0] C_SLOT_OD  = 16'(T_SLOT_OD_US * CLK_MHZ);

   // ROM function command codes
   localparam logic [7:0] CMD_READ_ID     = 8'h33;
   localparam logic [7:0] CMD_MATCH_ID    = 8'h55;
   localparam logic [7:0] CMD_SEARCH      = 8'hf0;
   localparam logic [7:0] CMD_COND_SEARCH = 8'hec;
   localparam logic [7:0] CMD_COND_READ   = 8'h0f;
   localparam logic [7:0] CMD_SKIP        = 8'hcc;
   localparam logic [7:0] CMD_OD_SKIP     = 8'h3c;
   localparam logic [7:0] CMD_OD_MATCH    = 8'h69;

   // Chain control byte values
   localparam logic [7:0] CHAIN_CODE_OFF  = 8'h3c;
   localparam logic [7:0] CHAIN_CODE_ON   = 8'h5a;
   localparam logic [7:0] CHAIN_CODE_DONE = 8'h96;

   typedef enum logic [1:0] {
      CHAIN_OFF  = 2'b00,
      CHAIN_ON   = 2'b01,
      CHAIN_DONE = 2'b10
   } chain_t;

   typedef enum logic [1:0] {
      OP_RESET = 2'b00,
      OP_WRITE = 2'b01,
      OP_READ  = 2'b10
   } op_t;

   // Selects the standard or overdrive figure
   function automatic logic [15:0] pick(input logic od, input logic [15:0] std_v,
                                        input logic [15:0] od_v);
      return od ? od_v : std_v;
   endfunction : pick

endpackage : swl_pkg

// >>> common/swl_if.sv
// Shared open-drain line between device end and master end
`timescale 1ns/10ps
interface swl_if;
   logic dev_dq_o;
   logic dev_dq_oe;
   logic mst_dq_o;
   logic mst_dq_oe;
   wire  dq;

   // Wired-AND: the line is low whenever any end pulls it low
   assign dq = ~((dev_dq_oe & ~dev_dq_o) | (mst_dq_oe & ~mst_dq_o));

   modport device (input dq, output dev_dq_o, output dev_dq_oe);
   modport master (input dq, output mst_dq_o, output mst_dq_oe);
endinterface : swl_if

// >>> verilog/swl_device.sv
// Device end: reset/presence, ROM command decode, read, match and search
`timescale 1ns/10ps
module swl_device #(
   parameter int OD_EXIT_CYC = swl_pkg::C_ODEXIT
) (
   input  wire logic          ref_clk,
   input  wire logic          resetn,
   swl_if.device              line,
   input  wire logic [63:0]   rom_id,
   input  wire logic          temp_alarm,
   input  wire logic          second_port_pin,
   input  wire logic          chain_ctrl_valid,
   input  wire logic [7:0]    chain_ctrl_byte,
   output logic               selected,
   output logic               overdrive,
   output logic               ctrl_bit_valid,
   output logic               ctrl_bit,
   output swl_pkg::chain_t    chain_state
);

   typedef enum logic [2:0] {
      ST_WAIT_RST  = 3'b000,
      ST_PRES_WAIT = 3'b001,
      ST_PRES_LOW  = 3'b010,
      ST_ROM_CMD   = 3'b011,
      ST_SEND_ID   = 3'b100,
      ST_MATCH     = 3'b101,
      ST_SEARCH    = 3'b110,
      ST_SELECTED  = 3'b111
   } dev_state_t;

   dev_state_t  state_r;
   logic        dq_s1_r;
   logic        dq_s2_r;
   logic        dq_d_r;
   logic        en_s1_r;
   logic        en_s2_r;
   logic [15:0] low_cnt_r;
   logic [15:0] tmr_r;
   logic        in_slot_r;
   logic        dq_oe_r;
   logic [5:0]  bit_idx_r;
   logic [1:0]  phase_r;
   logic [7:0]  cmd_sr_r;
   logic        match_ok_r;

   logic        fall;
   logic        rise;
   logic        bus_rst;
   logic        od_exit;
   logic        slot_ok;
   logic        slot_end;
   logic        pres_start;
   logic        pres_end;
   logic        tx_zero;
   logic        own_bit;
   logic        rx;
   logic        cmd_done;
   logic [7:0]  cmd_full;

   assign line.dev_dq_o  = 1'b0;
   assign line.dev_dq_oe = dq_oe_r;

   assign rx       = dq_s2_r;
   assign own_bit  = rom_id[bit_idx_r];
   assign fall     = dq_d_r & ~dq_s2_r;
   assign rise     = ~dq_d_r & dq_s2_r;
   assign bus_rst  = rise && (low_cnt_r >= swl_pkg::pick(overdrive, swl_pkg::C_RSTDET_STD,
                                                       swl_pkg::C_RSTDET_OD));
   assign od_exit  = ({16'h0000, low_cnt_r} >= 32'(OD_EXIT_CYC));
   assign slot_ok  = (state_r == ST_ROM_CMD) || (state_r == ST_SEND_ID) ||
                     (state_r == ST_MATCH) || (state_r == ST_SEARCH) ||
                     (state_r == ST_SELECTED);
   assign slot_end = in_slot_r && (tmr_r == swl_pkg::pick(overdrive, swl_pkg::C_DSAMP_STD,
                                                          swl_pkg::C_DSAMP_OD));
   assign pres_start = (state_r == ST_PRES_WAIT) &&
                       (tmr_r == swl_pkg::pick(overdrive, swl_pkg::C_PDH_STD, swl_pkg::C_PDH_OD));
   assign pres_end   = (state_r == ST_PRES_LOW) &&
                       (tmr_r == swl_pkg::pick(overdrive, swl_pkg::C_PDL_STD, swl_pkg::C_PDL_OD));
   assign cmd_done = slot_end && (state_r == ST_ROM_CMD) && (bit_idx_r == 6'd7);
   assign cmd_full = {rx, cmd_sr_r[7:1]};

   // Bit to pull low in the slot that starts now
   always_comb begin
      case (state_r)
         ST_SEND_ID: tx_zero = ~own_bit;
         ST_SEARCH:  tx_zero = (phase_r == 2'd0) ? ~own_bit : (phase_r == 2'd1) && own_bit;
         default:    tx_zero = 1'b0;
      endcase
   end

   // Line and enable pin synchronisers
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dq_s1_r <= 1'b1;
         dq_s2_r <= 1'b1;
         dq_d_r  <= 1'b1;
         en_s1_r <= 1'b1;
         en_s2_r <= 1'b1;
      end else begin
         dq_s1_r <= line.dq;
         dq_s2_r <= dq_s1_r;
         dq_d_r  <= dq_s2_r;
         en_s1_r <= second_port_pin;
         en_s2_r <= en_s1_r;
      end
   end

   // Length of the current low phase of the line
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         low_cnt_r <= 16'h0000;
      end else if (dq_s2_r) begin
         low_cnt_r <= 16'h0000;
      end else if (low_cnt_r != 16'hffff) begin
         low_cnt_r <= low_cnt_r + 16'h0001;
      end
   end

   // Timer for presence phases and slots
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tmr_r <= 16'h0000;
      end else if (bus_rst || pres_start || pres_end || (fall && slot_ok)) begin
         tmr_r <= 16'h0000;
      end else if (tmr_r != 16'hffff) begin
         tmr_r <= tmr_r + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         in_slot_r <= 1'b0;
      end else if (bus_rst) begin
         in_slot_r <= 1'b0;
      end else if (fall && slot_ok) begin
         in_slot_r <= 1'b1;
      end else if (slot_end) begin
         in_slot_r <= 1'b0;
      end
   end

   // Pulldown only; never drives the line high
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dq_oe_r <= 1'b0;
      end else if (bus_rst || pres_end || slot_end) begin
         dq_oe_r <= 1'b0;
      end else if (pres_start) begin
         dq_oe_r <= 1'b1;
      end else if (fall && slot_ok && tx_zero) begin
         dq_oe_r <= 1'b1;
      end
   end

   // Speed: set by the overdrive commands, cleared by a long reset
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         overdrive <= 1'b0;
      end else if (bus_rst && od_exit) begin
         overdrive <= 1'b0;
      end else if (cmd_done && (cmd_full == swl_pkg::CMD_OD_SKIP ||
                                cmd_full == swl_pkg::CMD_OD_MATCH)) begin
         overdrive <= 1'b1;
      end
   end

   // Chain state kept for the conditional read
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         chain_state <= swl_pkg::CHAIN_OFF;
      end else if (chain_ctrl_valid) begin
         case (chain_ctrl_byte)
            swl_pkg::CHAIN_CODE_OFF:  chain_state <= swl_pkg::CHAIN_OFF;
            swl_pkg::CHAIN_CODE_ON:   chain_state <= swl_pkg::CHAIN_ON;
            swl_pkg::CHAIN_CODE_DONE: chain_state <= swl_pkg::CHAIN_DONE;
            default:                  chain_state <= chain_state;
         endcase
      end
   end

   // Bits of the control phase handed to the user side
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_bit_valid <= 1'b0;
         ctrl_bit       <= 1'b0;
      end else begin
         ctrl_bit_valid <= slot_end && (state_r == ST_SELECTED);
         if (slot_end && (state_r == ST_SELECTED)) begin
            ctrl_bit <= rx;
         end
      end
   end

   // Transaction sequencer
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r    <= ST_WAIT_RST;
         bit_idx_r  <= 6'd0;
         phase_r    <= 2'd0;
         cmd_sr_r   <= 8'h00;
         match_ok_r <= 1'b1;
         selected   <= 1'b0;
      end else if (bus_rst) begin
         state_r    <= ST_PRES_WAIT;
         bit_idx_r  <= 6'd0;
         phase_r    <= 2'd0;
         cmd_sr_r   <= 8'h00;
         match_ok_r <= 1'b1;
         selected   <= 1'b0;
      end else begin
         case (state_r)
            ST_PRES_WAIT: begin
               if (pres_start) begin
                  state_r <= ST_PRES_LOW;
               end
            end
            ST_PRES_LOW: begin
               if (pres_end) begin
                  state_r <= ST_ROM_CMD;
               end
            end
            ST_ROM_CMD: begin
               if (slot_end) begin
                  cmd_sr_r  <= cmd_full;
                  bit_idx_r <= bit_idx_r + 6'd1;
               end
               if (cmd_done) begin
                  bit_idx_r <= 6'd0;
                  case (cmd_full)
                     swl_pkg::CMD_READ_ID: state_r <= ST_SEND_ID;
                     swl_pkg::CMD_COND_READ:
                        state_r <= (chain_state == swl_pkg::CHAIN_ON && !en_s2_r) ?
                                   ST_SEND_ID : ST_WAIT_RST;
                     swl_pkg::CMD_MATCH_ID, swl_pkg::CMD_OD_MATCH:
                        state_r <= ST_MATCH;
                     swl_pkg::CMD_SEARCH: state_r <= ST_SEARCH;
                     swl_pkg::CMD_COND_SEARCH:
                        state_r <= temp_alarm ? ST_SEARCH : ST_WAIT_RST;
                     swl_pkg::CMD_SKIP, swl_pkg::CMD_OD_SKIP: begin
                        state_r  <= ST_SELECTED;
                        selected <= 1'b1;
                     end
                     default: state_r <= ST_WAIT_RST;
                  endcase
               end
            end
            ST_SEND_ID: begin
               if (slot_end) begin
                  bit_idx_r <= bit_idx_r + 6'd1;
                  if (bit_idx_r == 6'd63) begin
                     state_r  <= ST_SELECTED;
                     selected <= 1'b1;
                  end
               end
            end
            ST_MATCH: begin
               if (slot_end) begin
                  bit_idx_r <= bit_idx_r + 6'd1;
                  if (rx != own_bit) begin
                     match_ok_r <= 1'b0;
                  end
                  if (bit_idx_r == 6'd63) begin
                     if (match_ok_r && (rx == own_bit)) begin
                        state_r  <= ST_SELECTED;
                        selected <= 1'b1;
                     end else begin
                        state_r <= ST_WAIT_RST;
                     end
                  end
               end
            end
            ST_SEARCH: begin
               if (slot_end) begin
                  if (phase_r != 2'd2) begin
                     phase_r <= phase_r + 2'd1;
                  end else if (rx != own_bit) begin
                     state_r <= ST_WAIT_RST;
                  end else begin
                     phase_r   <= 2'd0;
                     bit_idx_r <= bit_idx_r + 6'd1;
                     if (bit_idx_r == 6'd63) begin
                        state_r  <= ST_SELECTED;
                        selected <= 1'b1;
                     end
                  end
               end
            end
            ST_SELECTED: state_r <= ST_SELECTED;
            ST_WAIT_RST: state_r <= ST_WAIT_RST;
            default:     state_r <= ST_WAIT_RST;
         endcase
      end
   end

endmodule : swl_device

// >>> verilog/swl_master.sv
// Master end: reset/presence, write and read slots on the shared line
`timescale 1ns/10ps
module swl_master #(
   parameter int RSTL_STD_CYC = swl_pkg::C_RSTL_STD,
   parameter int RSTH_STD_CYC = swl_pkg::C_RSTH_STD
) (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   swl_if.master            line,
   input  wire logic        speed_od,
   input  wire logic        req_valid,
   input  wire swl_pkg::op_t req_op,
   input  wire logic        req_bit,
   output logic             req_ready,
   output logic             done,
   output logic             rd_bit,
   output logic             presence
);

   typedef enum logic [2:0] {
      M_IDLE      = 3'b000,
      M_RST_LOW   = 3'b001,
      M_RST_HIGH  = 3'b010,
      M_SLOT_LOW  = 3'b011,
      M_SLOT_HIGH = 3'b100
   } mst_state_t;

   mst_state_t  state_r;
   logic        dq_s1_r;
   logic        dq_s2_r;
   logic        dq_oe_r;
   logic        od_r;
   logic        wr_bit_r;
   logic        is_read_r;
   logic [15:0] tmr_r;
   logic [15:0] rstl;
   logic [15:0] rsth;
   logic [15:0] low_len;

   assign line.mst_dq_o  = 1'b0;
   assign line.mst_dq_oe = dq_oe_r;

   assign rstl    = swl_pkg::pick(od_r, 16'(RSTL_STD_CYC), swl_pkg::C_RSTL_OD);
   assign rsth    = swl_pkg::pick(od_r, 16'(RSTH_STD_CYC), swl_pkg::C_RSTH_OD);
   assign low_len = (wr_bit_r || is_read_r) ?
                    swl_pkg::pick(od_r, swl_pkg::C_W1L_STD, swl_pkg::C_W1L_OD) :
                    swl_pkg::pick(od_r, swl_pkg::C_W0L_STD, swl_pkg::C_W0L_OD);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dq_s1_r <= 1'b1;
         dq_s2_r <= 1'b1;
      end else begin
         dq_s1_r <= line.dq;
         dq_s2_r <= dq_s1_r;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r   <= M_IDLE;
         tmr_r     <= 16'h0000;
         dq_oe_r   <= 1'b0;
         od_r      <= 1'b0;
         wr_bit_r  <= 1'b1;
         is_read_r <= 1'b0;
         req_ready <= 1'b0;
         done      <= 1'b0;
         rd_bit    <= 1'b1;
         presence  <= 1'b0;
      end else begin
         done  <= 1'b0;
         tmr_r <= tmr_r + 16'h0001;
         case (state_r)
            M_IDLE: begin
               // Line stays released while idle
               dq_oe_r   <= 1'b0;
               req_ready <= 1'b1;
               tmr_r     <= 16'h0000;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  od_r      <= speed_od;
                  wr_bit_r  <= req_bit;
                  is_read_r <= (req_op == swl_pkg::OP_READ);
                  dq_oe_r   <= 1'b1;
                  state_r   <= (req_op == swl_pkg::OP_RESET) ? M_RST_LOW : M_SLOT_LOW;
               end
            end
            M_RST_LOW: begin
               if (tmr_r == rstl) begin
                  dq_oe_r  <= 1'b0;
                  tmr_r    <= 16'h0000;
                  presence <= 1'b0;
                  state_r  <= M_RST_HIGH;
               end
            end
            M_RST_HIGH: begin
               if (tmr_r == swl_pkg::pick(od_r, swl_pkg::C_MSP_STD, swl_pkg::C_MSP_OD)) begin
                  presence <= ~dq_s2_r;
               end
               if (tmr_r == rsth) begin
                  done    <= 1'b1;
                  state_r <= M_IDLE;
               end
            end
            M_SLOT_LOW: begin
               if (tmr_r == low_len) begin
                  dq_oe_r <= 1'b0;
                  state_r <= M_SLOT_HIGH;
               end
            end
            M_SLOT_HIGH: begin
               if (tmr_r == swl_pkg::pick(od_r, swl_pkg::C_MSR_STD, swl_pkg::C_MSR_OD)) begin
                  rd_bit <= dq_s2_r;
               end
               // Slot length keeps the bit rate in limits
               if (tmr_r == swl_pkg::pick(od_r, swl_pkg::C_SLOT_STD, swl_pkg::C_SLOT_OD)) begin
                  done    <= 1'b1;
                  state_r <= M_IDLE;
               end
            end
            default: state_r <= M_IDLE;
         endcase
      end
   end

endmodule : swl_master

// >>> tb/swl_rom_chk.sv
// Checker on the shared line between device end and master end
`timescale 1ns/10ps
module swl_rom_chk (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic dq,
   input wire logic dev_dq_o,
   input wire logic dev_dq_oe,
   input wire logic mst_dq_o,
   input wire logic mst_dq_oe
);
   logic [15:0] mlow_r;
   logic [15:0] dlow_r;
   logic [15:0] gap_r;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Low length per end, and time since the last master fall
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mlow_r <= 16'h0000;
         dlow_r <= 16'h0000;
         gap_r  <= 16'hffff;
      end else begin
         mlow_r <= mst_dq_oe ? mlow_r + 16'h0001 : 16'h0000;
         dlow_r <= dev_dq_oe ? dlow_r + 16'h0001 : 16'h0000;
         if (mst_dq_oe && mlow_r == 16'h0000) gap_r <= 16'h0000;
         else if (gap_r != 16'hffff) gap_r <= gap_r + 16'h0001;
      end
   end

   sequence long_low_end;
      (mst_dq_oe && mlow_r >= 16'h095f) ##1 !mst_dq_oe;
   endsequence
   sequence pres_start;
      $rose(dev_dq_oe) && !mst_dq_oe;
   endsequence

   AST_PRES_AFTER_RST: assert property (long_low_end |-> ##[1:700] dev_dq_oe)
      else $error("no presence after reset");
   AST_PRES_MIN: assert property (pres_start |-> dev_dq_oe[*8])
      else $error("presence too short");
   AST_DEV_PULL_MAX: assert property (dlow_r < 16'h0960)
      else $error("device low too long");
   AST_RD_RELEASE: assert property ($rose(dev_dq_oe) && mst_dq_oe |-> ##[1:650] !dev_dq_oe)
      else $error("read bit not released");
   AST_DEV_OD: assert property (dev_dq_oe |-> !dev_dq_o)
      else $error("device drives high");
   AST_MST_OD: assert property (mst_dq_oe |-> !mst_dq_o)
      else $error("master drives high");
   AST_WIRED_AND: assert property (dq == !(dev_dq_oe || mst_dq_oe))
      else $error("line level wrong");
   AST_BIT_RATE: assert property ($rose(mst_dq_oe) |-> gap_r >= 16'h00a0)
      else $error("slots too close");
endmodule : swl_rom_chk

// >>> tb/single_wire_rom_command_layer_bench.sv
// Self-checking bench driving the user sides of both ends
`timescale 1ns/10ps
module single_wire_rom_command_layer_bench;
   logic            ref_clk = 1'b0;
   logic            resetn = 1'b0;
   logic [63:0]     rom_id;
   logic            temp_alarm = 1'b0;
   logic            second_port_pin = 1'b1;
   logic            chain_ctrl_valid = 1'b0;
   logic [7:0]      chain_ctrl_byte = 8'h00;
   logic            selected, overdrive, ctrl_bit_valid, ctrl_bit, last_ctrl;
   swl_pkg::chain_t chain_state;
   logic            speed_od = 1'b0, req_valid = 1'b0, req_bit = 1'b0;
   logic            req_ready, done, rd_bit, presence;
   swl_pkg::op_t    req_op = swl_pkg::OP_RESET;
   logic [63:0]     v;
   logic [7:0]      codes [3] = '{8'ha5, swl_pkg::CMD_COND_SEARCH, swl_pkg::CMD_COND_READ};
   int              n_mismatch = 0, checked = 0, seed = 32'h0547, n_ctrl = 0, i;

   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (ctrl_bit_valid === 1'b1) begin
      n_ctrl++;
      last_ctrl = ctrl_bit;
   end

   swl_if bus ();
   swl_device #(.OD_EXIT_CYC(2450)) swl_device_i (.ref_clk(ref_clk), .resetn(resetn),
      .line(bus.device), .rom_id(rom_id), .temp_alarm(temp_alarm),
      .second_port_pin(second_port_pin), .chain_ctrl_valid(chain_ctrl_valid),
      .chain_ctrl_byte(chain_ctrl_byte), .selected(selected), .overdrive(overdrive),
      .ctrl_bit_valid(ctrl_bit_valid), .ctrl_bit(ctrl_bit), .chain_state(chain_state));
   swl_master #(.RSTL_STD_CYC(2500), .RSTH_STD_CYC(3000)) swl_master_i (.ref_clk(ref_clk),
      .resetn(resetn), .line(bus.master), .speed_od(speed_od), .req_valid(req_valid),
      .req_op(req_op), .req_bit(req_bit), .req_ready(req_ready), .done(done),
      .rd_bit(rd_bit), .presence(presence));
   swl_rom_chk swl_rom_chk_i (.ref_clk(ref_clk), .resetn(resetn), .dq(bus.dq),
      .dev_dq_o(bus.dev_dq_o), .dev_dq_oe(bus.dev_dq_oe), .mst_dq_o(bus.mst_dq_o),
      .mst_dq_oe(bus.mst_dq_oe));

   task stop_test;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test

   task check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   // Expected read pair of a search triplet: true bit, then its complement
   function automatic logic [1:0] pair(input logic b);
      return {~b, b};
   endfunction : pair

   // One request on the master port, waits for its done pulse
   task xfer(input swl_pkg::op_t o, input logic b);
      int n;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 9000);
      req_op = o;
      req_bit = b;
      req_valid = 1'b1;
      @(negedge ref_clk);
      req_valid = 1'b0;
      // One budget covers both the wait for ready and the wait for done
      while (done !== 1'b1 && n < 18000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= 18000) begin
         n_mismatch++;
         stop_test();
      end
   endtask : xfer

   task wbyte(input logic [7:0] c);
      for (int k = 0; k < 8; k++) xfer(swl_pkg::OP_WRITE, c[k]);
   endtask : wbyte

   task rbit(output logic b);
      xfer(swl_pkg::OP_READ, 1'b1);
      b = rd_bit;
   endtask : rbit

   task brst(input logic od);
      @(negedge ref_clk);
      speed_od = od;
      xfer(swl_pkg::OP_RESET, 1'b0);
      check(presence, 1'b1);
   endtask : brst

   task chain(input logic [7:0] c, input swl_pkg::chain_t e);
      @(negedge ref_clk);
      chain_ctrl_byte = c;
      chain_ctrl_valid = 1'b1;
      @(negedge ref_clk);
      chain_ctrl_valid = 1'b0;
      @(negedge ref_clk);
      check(chain_state, e);
   endtask : chain

   task note(input string s);
      $display("test %s done", s);
   endtask : note

   initial begin
      rom_id = {$random(seed), $random(seed)};
      repeat (20) @(negedge ref_clk);
      check(chain_state, swl_pkg::CHAIN_OFF);
      resetn = 1'b1;
      brst(1'b0);
      wbyte(swl_pkg::CMD_OD_SKIP);
      check(overdrive, 1'b1);
      note("od_skip");
      brst(1'b1);
      wbyte(swl_pkg::CMD_READ_ID);
      for (i = 0; i < 64; i++) rbit(v[i]);
      check(v[7:0], rom_id[7:0]);
      check(v, rom_id);
      note("read_id");
      brst(1'b1);
      check(selected, 1'b0);
      wbyte(swl_pkg::CMD_SKIP);
      check(selected, 1'b1);
      i = n_ctrl;
      xfer(swl_pkg::OP_WRITE, 1'b0);
      check(n_ctrl, i + 1);
      check(last_ctrl, 1'b0);
      note("skip");
      chain(8'h5a, swl_pkg::CHAIN_ON);
      chain(8'h11, swl_pkg::CHAIN_ON);
      for (i = 0; i < 3; i++) begin
         brst(1'b1);
         wbyte(codes[i]);
         rbit(v[0]);
         check(v[0], 1'b1);
         check(selected, 1'b0);
      end
      note("silent");
      @(negedge ref_clk);
      second_port_pin = 1'b0;
      brst(1'b1);
      wbyte(swl_pkg::CMD_COND_READ);
      for (i = 0; i < 8; i++) rbit(v[i]);
      check(v[7:0], rom_id[7:0]);
      note("cond_read");
      chain(8'h96, swl_pkg::CHAIN_DONE);
      chain(8'h3c, swl_pkg::CHAIN_OFF);
      temp_alarm = 1'b1;
      brst(1'b1);
      wbyte(swl_pkg::CMD_COND_SEARCH);
      rbit(v[0]);
      rbit(v[1]);
      check(v[1:0], pair(rom_id[0]));
      xfer(swl_pkg::OP_WRITE, ~rom_id[0]);
      rbit(v[0]);
      rbit(v[1]);
      check(v[1:0], 2'b11);
      note("drop");
      brst(1'b1);
      wbyte(swl_pkg::CMD_SEARCH);
      for (i = 0; i < 64; i++) begin
         rbit(v[0]);
         rbit(v[1]);
         check(v[1:0], pair(rom_id[i]));
         xfer(swl_pkg::OP_WRITE, rom_id[i]);
      end
      check(selected, 1'b1);
      note("search");
      // Match with the last address bit wrong, then an exact overdrive match
      for (int j = 0; j < 2; j++) begin
         brst(1'b1);
         wbyte((j == 0) ? swl_pkg::CMD_MATCH_ID : swl_pkg::CMD_OD_MATCH);
         for (i = 0; i < 64; i++) xfer(swl_pkg::OP_WRITE, rom_id[i] ^ (j == 0 && i == 63));
         check(selected, j == 1);
      end
      note("match");
      brst(1'b0);
      check(overdrive, 1'b0);
      note("od_exit");
      stop_test();
   end
endmodule : single_wire_rom_command_layer_bench
